// ### hw/lock_gate_cfg.svh
// Register offsets, field positions and reset values of the output driver bank
`ifndef LOCK_GATE_CFG_SVH
`define LOCK_GATE_CFG_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define DRIVER_CTRL_CH6_OFS        10'h0f6
`define DRIVER_CTRL_CH7_OFS        10'h0f7
`define DRIVER_CTRL_CH8_OFS        10'h0f8
`define DRIVER_CTRL_CH9_OFS        10'h0f9
`define DRIVER_CTRL_CH10_OFS       10'h0fa
`define DRIVER_CTRL_CH11_OFS       10'h0fb
`define LOCK_GATE_ENABLE_LOW_OFS   10'h0fc
`define LOCK_GATE_ENABLE_HIGH_OFS  10'h0fd

// ---------------------------------------------------------------------------
// Driver control field positions
// ---------------------------------------------------------------------------
`define DRV_FORMAT_BIT             7
`define DRV_CMOS_B_ON_BIT          6
`define DRV_CMOS_A_ON_BIT          5
`define DRV_POL_B_BIT              4
`define DRV_POL_A_BIT              3
`define DRV_VOD_HI_BIT             2
`define DRV_VOD_LO_BIT             1
`define DRV_PWRDN_BIT              0

// ---------------------------------------------------------------------------
// Reset values
// ---------------------------------------------------------------------------
`define DRIVER_CTRL_RESET          8'h64
`define LOCK_GATE_LOW_RESET        8'h00
`define LOCK_GATE_HIGH_RESET       8'h00
`define LOCK_GATE_HIGH_MASK        8'h0f
`define READ_UNMAPPED_VALUE        8'h00

`endif

// ### hw/lock_gate_pkg.sv
// Types shared by the output driver bank modules
package lock_gate_pkg;

    typedef enum logic {
        FORMAT_PECL,
        FORMAT_CMOS
    } out_format_t;

    typedef struct packed {
        out_format_t format;
        logic        cmos_b_on;
        logic        cmos_a_on;
        logic        pol_b;
        logic        pol_a;
        logic [1:0]  vod_sel;
        logic        pwrdn;
    } driver_ctrl_t;

endpackage

// ### hw/driver_chan_if.sv
// Signals between the register bank and one output channel decoder
`timescale 1ns/1ps
interface driver_chan_if;
    import lock_gate_pkg::*;

    driver_ctrl_t ctrl;
    logic         gate_en;
    logic         lock_level;
    logic         other_pwrdn;
    logic         enable;
    logic         a_invert;
    logic         b_invert;
    logic         a_on;
    logic         b_on;

    modport bank (
        output ctrl,
        output gate_en,
        output lock_level,
        output other_pwrdn,
        input  enable,
        input  a_invert,
        input  b_invert,
        input  a_on,
        input  b_on
    );

    modport chan (
        input  ctrl,
        input  gate_en,
        input  lock_level,
        input  other_pwrdn,
        output enable,
        output a_invert,
        output b_invert,
        output a_on,
        output b_on
    );
endinterface

// ### hw/output_chan_decode.sv
// Polarity, pin-on and lock-gated enable decode for one output channel
`timescale 1ns/1ps
module output_chan_decode
    import lock_gate_pkg::*;
(
    driver_chan_if.chan ch
);

    // -----------------------------------------------------------------------
    // Enable gating, purely combinational
    // -----------------------------------------------------------------------
    always_comb begin
        ch.enable = ~ch.ctrl.pwrdn
                  & ~ch.other_pwrdn
                  & ~(ch.gate_en & ~ch.lock_level);
    end

    // -----------------------------------------------------------------------
    // Polarity and pin-on decode
    // -----------------------------------------------------------------------
    always_comb begin
        ch.a_invert = ch.ctrl.pol_a;
        if (ch.ctrl.format == FORMAT_CMOS) begin
            ch.b_invert = ch.ctrl.pol_b ^ ch.ctrl.pol_a;
            ch.a_on     = ch.enable & ch.ctrl.cmos_a_on;
            ch.b_on     = ch.enable & ch.ctrl.cmos_b_on;
        end else begin
            ch.b_invert = ~ch.ctrl.pol_a;
            ch.a_on     = ch.enable;
            ch.b_on     = ch.enable;
        end
    end

endmodule // output_chan_decode

// ### hw/lock_gated_output_enable.sv
// Driver control registers for clock outputs six to eleven, lock-gate registers for outputs zero to eleven
//
// Summary of operation
// - Six 8-bit driver control registers, consecutive
// - Gate bit clear: lock level ignored
// - Gate bit set: enable follows lock level
// - Low gate register: outputs zero to seven
// - High gate register: outputs eight to eleven
// - Polarity bits with format select pin inversion
// - Bit zero forces driver safe power-down
`timescale 1ns/1ps
`include "lock_gate_cfg.svh"
module lock_gated_output_enable
    import lock_gate_pkg::*;
#(
    parameter int ADDR_W  = 10,
    parameter int N_CTRL  = 6,
    parameter int N_OUT   = 12,
    parameter int FIRST_C = 6
) (
    input  wire logic                   clk,
    input  wire logic                   resetn,
    input  wire logic [ADDR_W-1:0]      reg_addr,
    input  wire logic                   reg_wr,
    input  wire logic [7:0]             reg_wdata,
    input  wire logic                   reg_rd,
    output logic      [7:0]             reg_rdata,
    output logic                        reg_rvalid,
    input  wire logic                   current_source_lock_signal,
    input  wire logic [N_OUT-1:0]       other_pwrdn,
    output logic      [N_OUT-1:0]       drive_enable,
    output logic      [N_CTRL-1:0]      a_invert,
    output logic      [N_CTRL-1:0]      b_invert,
    output logic      [N_CTRL-1:0]      a_on,
    output logic      [N_CTRL-1:0]      b_on,
    output logic      [N_CTRL-1:0]      cmos_mode,
    output logic      [N_CTRL-1:0][1:0] vod_sel
);

    // -----------------------------------------------------------------------
    // Address decode helpers
    // -----------------------------------------------------------------------
    localparam logic [ADDR_W-1:0] CTRL_BASE = `DRIVER_CTRL_CH6_OFS;
    localparam logic [ADDR_W-1:0] CTRL_LAST = `DRIVER_CTRL_CH11_OFS;

    function automatic logic is_ctrl(input logic [ADDR_W-1:0] a);
        return (a >= CTRL_BASE) && (a <= CTRL_LAST);
    endfunction

    function automatic logic [2:0] ctrl_index(input logic [ADDR_W-1:0] a);
        logic [ADDR_W-1:0] diff;
        diff = a - CTRL_BASE;
        return diff[2:0];
    endfunction

    // Enable for a gated output with no local control register
    function automatic logic gated_enable(input logic gate,
                                          input logic lock_lvl,
                                          input logic pd);
        return ~pd & ~(gate & ~lock_lvl);
    endfunction

    // -----------------------------------------------------------------------
    // Register state
    // -----------------------------------------------------------------------
    driver_ctrl_t [N_CTRL-1:0] ctrl_q;
    driver_ctrl_t [N_CTRL-1:0] ctrl_d;
    logic         [7:0]        gate_low_q;
    logic         [7:0]        gate_low_d;
    logic         [3:0]        gate_high_q;
    logic         [3:0]        gate_high_d;
    logic         [7:0]        rdata_q;
    logic                      rvalid_q;
    logic         [7:0]        rdata_d;
    logic         [N_OUT-1:0]  gate_all;
    logic                      hit_ctrl;
    logic                      hit_low;
    logic                      hit_high;

    logic wr_ctrl;
    logic wr_low;
    logic wr_high;

    // -----------------------------------------------------------------------
    // Address hits, shared by the write and read paths
    // -----------------------------------------------------------------------
    // Both strobes may hit in one cycle; the read then sees the old value
    assign hit_ctrl = is_ctrl(reg_addr);
    assign hit_low  = (reg_addr == `LOCK_GATE_ENABLE_LOW_OFS);
    assign hit_high = (reg_addr == `LOCK_GATE_ENABLE_HIGH_OFS);

    assign wr_ctrl = reg_wr & hit_ctrl;
    assign wr_low  = reg_wr & hit_low;
    assign wr_high = reg_wr & hit_high;

    // -----------------------------------------------------------------------
    // Driver control registers
    // -----------------------------------------------------------------------
    // Only offsets that pass is_ctrl reach the index, so it stays below six
    always_comb begin
        ctrl_d = ctrl_q;
        if (wr_ctrl) begin
            ctrl_d[ctrl_index(reg_addr)] = driver_ctrl_t'(reg_wdata);
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            for (int i = 0; i < N_CTRL; i++) begin
                ctrl_q[i] <= driver_ctrl_t'(`DRIVER_CTRL_RESET);
            end
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // -----------------------------------------------------------------------
    // Lock-gate enable registers
    // -----------------------------------------------------------------------
    // Upper nibble of the high register has no storage
    always_comb begin
        gate_low_d  = gate_low_q;
        gate_high_d = gate_high_q;
        if (wr_low) begin
            gate_low_d = reg_wdata;
        end
        if (wr_high) begin
            gate_high_d = reg_wdata[3:0];
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_low_q <= `LOCK_GATE_LOW_RESET;
        end else begin
            gate_low_q <= gate_low_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            gate_high_q <= 4'(`LOCK_GATE_HIGH_RESET);
        end else begin
            gate_high_q <= gate_high_d;
        end
    end

    assign gate_all = {gate_high_q, gate_low_q};

    // -----------------------------------------------------------------------
    // Read path
    // -----------------------------------------------------------------------
    // Offsets outside the bank read as zero
    always_comb begin
        rdata_d = `READ_UNMAPPED_VALUE;
        if (hit_ctrl) begin
            rdata_d = ctrl_q[ctrl_index(reg_addr)];
        end else if (hit_low) begin
            rdata_d = gate_low_q;
        end else if (hit_high) begin
            rdata_d = {4'h0, gate_high_q} & `LOCK_GATE_HIGH_MASK;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= 8'h00;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= reg_rd;
        end
    end

    assign reg_rdata  = rdata_q;
    assign reg_rvalid = rvalid_q;

    // -----------------------------------------------------------------------
    // Outputs without a local control register
    // -----------------------------------------------------------------------
    // Lock level goes straight to the enable; no clock on this path
    for (genvar o = 0; o < FIRST_C; o++) begin : g_bare
        assign drive_enable[o] = gated_enable(gate_all[o],
                                              current_source_lock_signal,
                                              other_pwrdn[o]);
    end

    // -----------------------------------------------------------------------
    // Channels with local control registers
    // -----------------------------------------------------------------------
    for (genvar c = 0; c < N_CTRL; c++) begin : g_chan
        driver_chan_if chan_if ();

        assign chan_if.ctrl        = ctrl_q[c];
        assign chan_if.gate_en     = gate_all[FIRST_C + c];
        assign chan_if.lock_level  = current_source_lock_signal;
        assign chan_if.other_pwrdn = other_pwrdn[FIRST_C + c];

        output_chan_decode u_decode (
            .ch (chan_if.chan)
        );

        assign drive_enable[FIRST_C + c] = chan_if.enable;
        assign a_invert[c]               = chan_if.a_invert;
        assign b_invert[c]               = chan_if.b_invert;
        assign a_on[c]                   = chan_if.a_on;
        assign b_on[c]                   = chan_if.b_on;
        assign cmos_mode[c]              = (ctrl_q[c].format == FORMAT_CMOS);
        assign vod_sel[c]                = ctrl_q[c].vod_sel;
    end

endmodule // lock_gated_output_enable

// ### verification/lock_gated_output_enable_chk.sv
// Port checker for the lock-gated output driver bank
`timescale 1ns/1ps
module lock_gated_output_enable_chk #(
    parameter int ADDR_W = 10,
    parameter int N_CTRL = 6,
    parameter int N_OUT  = 12
) (
    input wire logic              clk,
    input wire logic              resetn,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [7:0]        reg_rdata,
    input wire logic              reg_rvalid,
    input wire logic              current_source_lock_signal,
    input wire logic [N_OUT-1:0]  other_pwrdn,
    input wire logic [N_OUT-1:0]  drive_enable,
    input wire logic [N_CTRL-1:0] a_invert,
    input wire logic [N_CTRL-1:0] b_invert,
    input wire logic [N_CTRL-1:0] a_on,
    input wire logic [N_CTRL-1:0] b_on,
    input wire logic [N_CTRL-1:0] cmos_mode
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    rd_answer_a: assert property (reg_rvalid == $past(reg_rd))
        else $error("read answer late");
    rdata_hold_a: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
        else $error("rdata moved");
    high_rsvd_a: assert property (reg_rvalid && $past(reg_addr) == 10'h0fd
        |-> reg_rdata[7:4] == 4'h0)
        else $error("upper gate bits not zero");
    unmapped_a: assert property (reg_rvalid && ($past(reg_addr) < 10'h0f6
        || $past(reg_addr) > 10'h0fd) |-> reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    other_pd_a: assert property ((drive_enable & other_pwrdn) == '0)
        else $error("pd ignored");
    lock_rise_a: assert property ($rose(current_source_lock_signal) && !$past(reg_wr)
        && $stable(other_pwrdn) |-> (drive_enable & $past(drive_enable)) == $past(drive_enable))
        else $error("rise dropped");
    lock_fall_a: assert property ($fell(current_source_lock_signal) && !$past(reg_wr)
        && $stable(other_pwrdn) |-> (drive_enable & ~$past(drive_enable)) == '0)
        else $error("fall raised");
    pecl_pins_a: assert property ((~cmos_mode & (a_on ^ b_on)) == '0)
        else $error("pecl pins split");
    pecl_pol_a: assert property ((~cmos_mode & ~(a_invert ^ b_invert)) == '0)
        else $error("pecl pins not opposite");
    pin_off_a: assert property ((a_on & ~drive_enable[11:6]) == '0)
        else $error("pin on while off");
    cover property (reg_rvalid);
    cover property ($fell(current_source_lock_signal));
    cover property (drive_enable != ~other_pwrdn);
endmodule // lock_gated_output_enable_chk

bind lock_gated_output_enable lock_gated_output_enable_chk #(.ADDR_W(ADDR_W), .N_CTRL(N_CTRL),
    .N_OUT(N_OUT)) u_lock_gated_output_enable_chk (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .current_source_lock_signal(current_source_lock_signal), .other_pwrdn(other_pwrdn),
    .drive_enable(drive_enable), .a_invert(a_invert), .b_invert(b_invert), .a_on(a_on),
    .b_on(b_on), .cmos_mode(cmos_mode));

// ### verification/test_lock_gated_output_enable.sv
// Self-checking bench for the lock-gated output driver bank
`timescale 1ns/1ps
module test_lock_gated_output_enable;
    import lock_gate_pkg::*;
    logic             clk, resetn, reg_wr, reg_rd, lock, reg_rvalid;
    logic [9:0]       reg_addr;
    logic [7:0]       reg_wdata, reg_rdata, sh [0:7];
    logic [11:0]      other_pwrdn, drive_enable;
    logic [5:0]       a_invert, b_invert, a_on, b_on, cmos_mode;
    logic [5:0][1:0]  vod_sel;
    int               err_count, check_count;

    lock_gated_output_enable u_lock_gated_output_enable (.clk(clk), .resetn(resetn),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .current_source_lock_signal(lock),
        .other_pwrdn(other_pwrdn), .drive_enable(drive_enable), .a_invert(a_invert),
        .b_invert(b_invert), .a_on(a_on), .b_on(b_on), .cmos_mode(cmos_mode), .vod_sel(vod_sel));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    task automatic cmp_reg(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic cmp_pin(input logic [11:0] g, input logic [11:0] e);
        check_count++;
        if (g !== e) begin
            err_count++;
            $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    function automatic logic [11:0] exp_en();
        logic [11:0] pd;
        pd = {sh[5][0], sh[4][0], sh[3][0], sh[2][0], sh[1][0], sh[0][0], 6'h00};
        return ~other_pwrdn & ~pd & ~({sh[7][3:0], sh[6]} & {12{~lock}});
    endfunction
    task automatic do_reset();
        resetn = 1'b0;
        for (int i = 0; i < 8; i++) sh[i] = (i < 6) ? 8'h64 : 8'h00;
        repeat (20) @(posedge clk);
        #1 resetn = 1'b1;
    endtask
    task automatic wr(input logic [9:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        if (a >= 10'h0f6 && a <= 10'h0fd) sh[a - 10'h0f6] = (a == 10'h0fd) ? (d & 8'h0f) : d;
        @(posedge clk) #1 reg_wr = 1'b0;
        @(posedge clk) #1;
    endtask
    task automatic rd_chk(input logic [9:0] a, input logic [7:0] e);
        reg_addr = a;
        reg_rd = 1'b1;
        @(posedge clk) #1 reg_rd = 1'b0;
        cmp_pin({11'h000, reg_rvalid}, 12'h001);
        cmp_reg(reg_rdata, e);
        @(posedge clk) #1;
    endtask
    task automatic conclude();
        $display("checks=%0d mismatches=%0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic t_reset();
        for (int i = 0; i < 8; i++) rd_chk(10'h0f6 + 10'(i), sh[i]);
        rd_chk(10'h0f5, 8'h00);
        rd_chk(10'h0fe, 8'h00);
        cmp_pin(drive_enable, exp_en());
        cmp_pin({a_invert, b_invert}, 12'h03f);
        $display("test reset done");
    endtask
    task automatic t_polarity();
        logic [7:0]  v;
        logic [11:0] pe;
        logic [1:0]  on;
        int          c;
        for (int k = 0; k < 8; k++) begin
            c = k % 6;
            v = {k[2], k[0], k[1], k[1:0], 2'b01, 1'b0};
            pe = {7'h00, k[2], k[0], k[2] ? k[1] ^ k[0] : ~k[0], 2'b01};
            on = k[2] ? {k[1], k[0]} : 2'b11;
            wr(10'h0f6 + 10'(c), v);
            cmp_pin({7'h00, cmos_mode[c], a_invert[c], b_invert[c], vod_sel[c]}, pe);
            cmp_pin({10'h000, a_on[c], b_on[c]}, {10'h000, on});
            rd_chk(10'h0f6 + 10'(c), v);
        end
        $display("test polarity done");
    endtask
    task automatic t_pwrdn();
        wr(10'h0f7, 8'h65);
        cmp_pin(drive_enable, exp_en());
        cmp_pin({10'h000, a_on[1], b_on[1]}, 12'h000);
        wr(10'h0f7, 8'h64);
        cmp_pin(drive_enable, exp_en());
        $display("test power-down done");
    endtask
    task automatic t_gate();
        lock = 1'b1;
        other_pwrdn = 12'h0a5;
        wr(10'h0fc, 8'h81);
        wr(10'h0fd, 8'hff);
        rd_chk(10'h0fd, 8'h0f);
        rd_chk(10'h0fc, 8'h81);
        cmp_pin(drive_enable, exp_en());
        @(posedge clk) #1 lock = 1'b0;
        #1 cmp_pin(drive_enable, exp_en());
        @(posedge clk) #1 other_pwrdn = 12'h000;
        #1 cmp_pin(drive_enable, exp_en());
        @(posedge clk) #1 lock = 1'b1;
        #1 cmp_pin(drive_enable, 12'hfff);
        @(posedge clk) #1 do_reset();
        rd_chk(10'h0fc, 8'h00);
        $display("test lock gate done");
    endtask

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        #200000 err_count++;
        conclude();
    end
    initial begin
        {reg_wr, reg_rd, lock, reg_addr, reg_wdata, other_pwrdn} = '0;
        err_count = 0;
        check_count = 0;
        do_reset();
        t_reset();
        t_polarity();
        t_pwrdn();
        t_gate();
        conclude();
    end
endmodule // test_lock_gated_output_enable
